// *** rtl/fps_pkg.sv ***
// Purpose: shared constants for the flash shared-pin link
// Assumes: SPI mode 0, host makes the serial clock
// Notes: host register map is APB, one aligned word each
package fps_pkg;
	// Data byte width on the link
	localparam int FPS_BYTE_BITS = 8;
	// Serial clock half period in core cycles
	localparam int FPS_SCK_HALF = 4;
	// Host register byte offsets
	localparam logic [7:0] FPS_CTRL_OFS = 8'h00;
	localparam logic [7:0] FPS_TXD_OFS = 8'h04;
	localparam logic [7:0] FPS_RXD_OFS = 8'h08;
	localparam logic [7:0] FPS_STAT_OFS = 8'h0C;
	// Control field positions
	localparam int FPS_CTRL_FRAME = 0;
	localparam int FPS_CTRL_HOLD = 1;
	localparam int FPS_CTRL_WPLOW = 2;
	localparam int FPS_CTRL_RSTLOW = 3;
	localparam int FPS_CTRL_QUAD = 4;
	localparam int FPS_CTRL_QREAD = 5;
	localparam int FPS_CTRL_BITS = 6;
	// Status field positions
	localparam int FPS_STAT_BUSY = 0;
	localparam int FPS_STAT_HELD = 1;
	localparam int FPS_STAT_SEL = 2;
	// Reset values
	localparam logic [5:0] FPS_CTRL_RST = 6'h00;
	localparam logic [7:0] FPS_TXD_RST = 8'h00;
	// Host sequencer states
	typedef enum logic [2:0] {
		FPS_IDLE = 3'b001,
		FPS_LOW = 3'b010,
		FPS_HIGH = 3'b100
	} fps_state_t;
endpackage : fps_pkg

// *** rtl/fps_link_if.sv ***
// Purpose: the four-line serial link between host and flash
// Assumes: host alone drives clock and select
// Notes: undriven lines resolve high, like the pin pull-ups
interface fps_link_if;
	logic sck; // Serial clock from host
	logic csN; // Chip select, active low
	logic [3:0] hostIoOut; // Host line values
	logic [3:0] hostIoOe; // Host drives line when high
	logic [3:0] devIoOut; // Device line values
	logic [3:0] devIoOe; // Device drives line when high
	wire [3:0] io; // Resolved line levels
	assign io = (hostIoOut & hostIoOe) | (devIoOut & devIoOe) | ~(hostIoOe | devIoOe);
	modport host (output sck, output csN, output hostIoOut, output hostIoOe, input io);
	modport dev (input sck, input csN, output devIoOut, output devIoOe, input io);
endinterface : fps_link_if

// *** rtl/fps_flash_dev.sv ***
// Purpose: flash end of the link, shared pin function select
// Assumes: clocked by the serial clock, mode 0 timing
// Notes: hold and reset pins act only when quad is off
//
// Contract
// - write protect only when quad 0, protect 01
// - protect pin low blocks status register writes
// - quad on makes pin two a data line
// - host ignores write protect while quad on
// - quad 0, select 0: line three pauses
// - quad 0, select 1: line three resets
// - quad on makes line three data only
// - pause keeps bit and byte position
// - host pauses only while chip selected
// - pause begins at falling edge, clock low
// - pause ends at rising edge, clock low
// - floating protect or pause pin reads high
// - sample on rising, drive on falling edge
// - select edges frame operations, idle ignores
module fps_flash_dev
	import fps_pkg::*;
(
	fps_link_if.dev link,
	input wire logic quadEnable,
	input wire logic statusProtectUpper,
	input wire logic statusProtectLower,
	input wire logic holdResetSelect,
	input wire logic quadXfer,
	input wire logic quadRead,
	input wire logic [7:0] txByte,
	output logic [7:0] rxByte,
	output logic rxValid,
	output logic [2:0] bitPos,
	output logic writeBlocked,
	output logic pauseActive,
	output logic hwResetActive
);
	// Selected while chip select is low
	wire selected;
	// Shared pin function decode
	wire protectMode;
	wire holdMode;
	wire resetMode;
	// Line three seen low while it means reset
	wire resetPinLow;
	// Current pause condition
	wire paused;
	// Clears all link state, select high or reset pin
	wire linkClear;
	// Four-line transfer really in use
	wire quadActive;
	// Bits taken per rising edge
	wire [2:0] step;
	// Next bit position and shift value
	wire [2:0] nxtCnt;
	wire [7:0] nxtRx;
	// A byte finishes on this edge
	wire byteDone;

	// Bit position within the byte
	logic [2:0] cntFf;
	// Receive shifter
	logic [7:0] rxShFf;
	// Last whole byte received
	logic [7:0] rxByteFf;
	// Byte strobe, one serial clock
	logic rxValidFf;
	// Transmit shifter
	logic [7:0] txShFf;
	// Output enable, set at first falling edge
	logic oeFf;

	assign selected = ~link.csN;

	assign protectMode = ~quadEnable & ~statusProtectUpper & statusProtectLower;
	assign holdMode = ~quadEnable & ~holdResetSelect;
	assign resetMode = ~quadEnable & holdResetSelect;

	// block status writes
	// A floating pin resolves high, so protection is off by default
	assign writeBlocked = protectMode & ~link.io[2];

	assign resetPinLow = resetMode & ~link.io[3];
	assign hwResetActive = resetPinLow;

	// pause follows the line level
	// The host moves its pause request only with the clock low, so the level
	// seen at each clock edge matches the edge-bounded pause window.
	assign paused = holdMode & selected & ~link.io[3];
	assign pauseActive = paused;

	// operation bounded by select
	// Async clear: the serial clock stands still outside frames
	assign linkClear = link.csN | resetPinLow;

	// upper lines carry data only with quad on
	assign quadActive = quadEnable & quadXfer;

	// Advance by one bit or one nibble
	assign step = quadActive ? 3'h4 : 3'h1;
	assign nxtCnt = cntFf + step;
	assign byteDone = (nxtCnt == 3'h0);

	// Shift in one line or four
	assign nxtRx = quadActive ? {rxShFf[3:0], link.io[3:0]} : {rxShFf[6:0], link.io[0]};

	// Rising edge: take input data
	// sample on rising edge
	always_ff @(posedge link.sck or posedge linkClear)
	begin
		if (linkClear)
		begin
			// Fresh frame starts at bit zero
			cntFf <= 3'h0;
			rxShFf <= 8'h00;
			rxByteFf <= 8'h00;
			rxValidFf <= 1'b0;
		end
		else if (paused)
		begin
			rxValidFf <= 1'b0;
		end
		else
		begin
			cntFf <= nxtCnt;
			rxShFf <= nxtRx;
			rxValidFf <= byteDone;
			// Keep the last whole byte
			if (byteDone)
			begin
				rxByteFf <= nxtRx;
			end
		end
	end

	// Falling edge: present output data
	// drive on falling edge
	always_ff @(negedge link.sck or posedge linkClear)
	begin
		if (linkClear)
		begin
			txShFf <= 8'h00;
			oeFf <= 1'b0;
		end
		else if (!paused)
		begin
			oeFf <= 1'b1;
			// Byte boundary loads the next byte
			if (cntFf == 3'h0)
			begin
				txShFf <= txByte;
			end
			// Nibble step in quad mode
			else if (quadActive)
			begin
				txShFf <= {txShFf[3:0], 4'h0};
			end
			// Single bit step otherwise
			else
			begin
				txShFf <= {txShFf[6:0], 1'b0};
			end
		end
	end

	// Quad read drives all four lines, single mode only the serial output
	assign link.devIoOut = (quadActive & quadRead) ? txShFf[7:4] : {2'b00, txShFf[7], 1'b0};

	// float while paused or idle
	// Gated by the live pause level: no clock edge marks its start
	// A quad write hands all four lines to the host, serial output included
	assign link.devIoOe = {4{oeFf & selected & ~paused}}
		& (quadActive ? (quadRead ? 4'hF : 4'h0) : 4'h2);

	// User-side views
	assign rxByte = rxByteFf;
	assign rxValid = rxValidFf;
	assign bitPos = cntFf;
endmodule : fps_flash_dev

// *** rtl/fps_flash_host.sv ***
// Purpose: host controller end of the shared-pin flash link
// Assumes: APB slave on core_clk, serial clock made by divider
// Notes: select and pause move only between bytes, clock low; protect and reset levels follow control writes
module fps_flash_host
	import fps_pkg::*;
#(
	parameter int SCK_HALF = FPS_SCK_HALF
)
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	fps_link_if.host link
);
	// Sampling needs the two-flop delay inside a half period
	if (SCK_HALF < 3 || SCK_HALF > 15)
	begin : gen_chk
		$error("SCK_HALF must be 3 to 15");
	end

	// Bus decode
	wire setupHit;
	wire accessHit;
	wire hitCtrl;
	wire hitTxd;
	wire hitRxd;
	wire hitStat;
	wire mapped;
	wire wrCtrl;
	wire wrTxd;
	wire [31:0] readMux;
	// Transfer start and mode
	wire canStart;
	wire startXfer;
	wire quadOn;
	wire lastBit;
	wire [3:0] nxtIoOut;
	wire [3:0] nxtIoOe;

	fps_state_t stateFf;
	logic [5:0] ctrlFf; // Control word
	logic [7:0] txShFf; // Transmit shifter
	logic [7:0] rxShFf; // Receive shifter
	logic [7:0] rxByteFf; // Last byte in
	logic [3:0] divFf; // Half period counter
	logic [2:0] leftFf; // Steps left in byte
	logic sckFf;
	logic csNFf;
	logic holdLowFf; // Pause request on line three
	logic [3:0] ioOutFf;
	logic [3:0] ioOeFf;
	logic [3:0] ioS1Ff; // First sync stage
	logic [3:0] ioS2Ff; // Second sync stage
	logic [31:0] prdataFf;
	logic preadyFf;
	logic pslverrFf;

	// APB decode, one wait-free access phase
	assign setupHit = psel & ~penable;
	assign accessHit = psel & penable & preadyFf;
	assign hitCtrl = (paddr == FPS_CTRL_OFS);
	assign hitTxd = (paddr == FPS_TXD_OFS);
	assign hitRxd = (paddr == FPS_RXD_OFS);
	assign hitStat = (paddr == FPS_STAT_OFS);
	assign mapped = hitCtrl | hitTxd | hitRxd | hitStat;
	assign wrCtrl = accessHit & pwrite & hitCtrl;
	assign wrTxd = accessHit & pwrite & hitTxd;

	// Read data, unmapped reads zero
	assign readMux = hitCtrl ? {26'h0, ctrlFf} :
		hitRxd ? {24'h0, rxByteFf} :
		hitStat ? {29'h0, ~csNFf, holdLowFf, stateFf != FPS_IDLE} : 32'h0;

	assign quadOn = ctrlFf[FPS_CTRL_QUAD];

	// start only selected and not paused
	assign canStart = (stateFf == FPS_IDLE) & ~csNFf & ~holdLowFf;
	assign startXfer = wrTxd & canStart;
	assign lastBit = (leftFf == 3'h0);

	// Line values: quad write drives four, single drives data on line zero plus protect and pause or reset levels
	assign nxtIoOut = quadOn ? txShFf[7:4] : {1'b0, ~ctrlFf[FPS_CTRL_WPLOW], 1'b0, txShFf[7]}
		& {2'b11, 2'b11};
	assign nxtIoOe = quadOn ? {4{~ctrlFf[FPS_CTRL_QREAD] & ~csNFf}} :
		{holdLowFf | ctrlFf[FPS_CTRL_RSTLOW], ctrlFf[FPS_CTRL_WPLOW], 1'b0, ~csNFf};

	// APB response registers
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			preadyFf <= 1'b0;
			pslverrFf <= 1'b0;
			prdataFf <= 32'h0;
		end
		else
		begin
			preadyFf <= setupHit;
			pslverrFf <= setupHit & ~mapped;
			prdataFf <= setupHit ? readMux : 32'h0;
		end
	end

	// Control word written by software
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			ctrlFf <= FPS_CTRL_RST;
		end
		else if (wrCtrl)
		begin
			ctrlFf <= pwdata[FPS_CTRL_BITS-1:0];
		end
	end

	// Two-flop sync of the link lines
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			ioS1Ff <= 4'hF;
			ioS2Ff <= 4'hF;
		end
		else
		begin
			ioS1Ff <= link.io;
			ioS2Ff <= ioS1Ff;
		end
	end

	// Sequencer: clock divider and bit shifting
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			stateFf <= FPS_IDLE;
			sckFf <= 1'b0;
			csNFf <= 1'b1;
			holdLowFf <= 1'b0;
			divFf <= 4'h0;
			leftFf <= 3'h0;
			txShFf <= FPS_TXD_RST;
			rxShFf <= 8'h00;
			rxByteFf <= 8'h00;
		end
		else
		begin
			unique case (stateFf)
				FPS_IDLE:
				begin
					csNFf <= ~ctrlFf[FPS_CTRL_FRAME];
					holdLowFf <= ctrlFf[FPS_CTRL_HOLD] & ~quadOn & ~csNFf
						& ctrlFf[FPS_CTRL_FRAME];
					if (startXfer)
					begin
						txShFf <= pwdata[7:0];
						leftFf <= quadOn ? 3'h1 : 3'h7;
						divFf <= 4'(SCK_HALF - 1);
						stateFf <= FPS_LOW;
					end
				end
				FPS_LOW:
				begin
					// Data set up while clock is low
					if (divFf == 4'h0)
					begin
						// host samples at its rising edge
						sckFf <= 1'b1;
						rxShFf <= quadOn ? {rxShFf[3:0], ioS2Ff} : {rxShFf[6:0], ioS2Ff[1]};
						divFf <= 4'(SCK_HALF - 1);
						stateFf <= FPS_HIGH;
					end
					else
					begin
						divFf <= divFf - 4'h1;
					end
				end
				FPS_HIGH:
				begin
					if (divFf == 4'h0)
					begin
						sckFf <= 1'b0;
						divFf <= 4'(SCK_HALF - 1);
						txShFf <= quadOn ? {txShFf[3:0], 4'h0} : {txShFf[6:0], 1'b0};
						leftFf <= leftFf - 3'h1;
						if (lastBit)
						begin
							rxByteFf <= rxShFf;
							stateFf <= FPS_IDLE;
						end
						else
						begin
							stateFf <= FPS_LOW;
						end
					end
					else
					begin
						divFf <= divFf - 4'h1;
					end
				end
			endcase
		end
	end

	// Registered pin drivers
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			ioOutFf <= 4'hF;
			ioOeFf <= 4'h0;
		end
		else
		begin
			ioOutFf <= nxtIoOut;
			ioOeFf <= nxtIoOe;
		end
	end

	assign link.sck = sckFf;
	assign link.csN = csNFf;
	assign link.hostIoOut = ioOutFf;
	assign link.hostIoOe = ioOeFf;
	assign prdata = prdataFf;
	assign pready = preadyFf;
	assign pslverr = pslverrFf;
endmodule : fps_flash_host

// *** verification/fps_link_assertions.sv ***
// Purpose: protocol checks on the shared-pin serial link
// Assumes: sampled on core_clk, default serial half period
// Notes: config levels unseen, so pin checks stay generic
module fps_link_assertions
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic sck,
	input wire logic csN,
	input wire logic [3:0] hostIoOut,
	input wire logic [3:0] hostIoOe,
	input wire logic [3:0] devIoOut,
	input wire logic [3:0] devIoOe,
	input wire [3:0] io
);
	timeunit 1ns;
	timeprecision 1ps;
	// One domain, so clock and reset once
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	// Full high phase, then the fall
	sequence hiPhase;
		sck [*4] ##1 !sck;
	endsequence
	// Lines settled before the sampling edge
	sequence linesHeld;
		$stable(hostIoOut) && $stable(devIoOut);
	endsequence
	sck_half_a: assert property ($rose(sck) |-> hiPhase) else $error("sck high phase");
	drive_edge_a: assert property ($rose(sck) |-> linesHeld) else $error("io moved");
	no_contend_a: assert property ((hostIoOe & devIoOe) == 4'h0) else $error("io clash");
	idle_float_a: assert property (csN |-> devIoOe == 4'h0) else $error("idle drive");
	idle_sck_a: assert property (csN |-> !sck) else $error("idle sck");
	sel_edge_a: assert property ($changed(csN) |-> !sck) else $error("select edge");
	hold_fall_a: assert property (!csN && $fell(io[3]) |-> !sck) else $error("hold fall");
	hold_rise_a: assert property (!csN && $rose(io[3]) |-> !sck) else $error("hold rise");
	pull_up_a: assert property ((hostIoOe[3:2] | devIoOe[3:2]) == 2'b00 |-> io[3:2] == 2'b11)
		else $error("float low");
endmodule : fps_link_assertions

// *** verification/tb_flash_multifunction_pin_select.sv ***
// Purpose: both link ends driven from APB and device config
// Assumes: default half period, pin changes between bytes
// Notes: pause cannot be entered mid-byte from the host
module tb_flash_multifunction_pin_select import fps_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr, re;
	logic [7:0] paddr, txb, rxb;
	logic [31:0] pwdata, prdata, rv;
	// Device config levels and outputs
	logic qe, spu, spl, hrs, qx, qr, rxv, wblk, pact, hrst;
	logic [2:0] bpos;
	int errors, checks;
	fps_link_if lnk();
	fps_flash_host i_fps_flash_host (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lnk.host));
	fps_flash_dev i_fps_flash_dev (.link(lnk.dev), .quadEnable(qe), .statusProtectUpper(spu),
		.statusProtectLower(spl), .holdResetSelect(hrs), .quadXfer(qx), .quadRead(qr),
		.txByte(txb), .rxByte(rxb), .rxValid(rxv), .bitPos(bpos), .writeBlocked(wblk),
		.pauseActive(pact), .hwResetActive(hrst));
	fps_link_assertions i_chk (.core_clk(core_clk), .rst_b(rst_b), .sck(lnk.sck),
		.csN(lnk.csN), .hostIoOut(lnk.hostIoOut), .hostIoOe(lnk.hostIoOe),
		.devIoOut(lnk.devIoOut), .devIoOe(lnk.devIoOe), .io(lnk.io));
	// Core clock
	always #5 core_clk = ~core_clk;
	// Compare and count
	task ck(input string n, input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : ck
	// One APB transfer, waits for pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		ck(n, rv, e);
	endtask : rdc
	// Poll busy, bounded
	task idle;
		rv = 32'h1;
		for (int i = 0; i < 100 && rv[FPS_STAT_BUSY] !== 1'b0; i++)
			apb(1'b0, FPS_STAT_OFS, 32'h0);
		// A poll limit that runs out counts as a mismatch
		ck("busy", rv[FPS_STAT_BUSY], 1'b0);
	endtask : idle
	task xfer(input logic [7:0] t);
		apb(1'b1, FPS_TXD_OFS, {24'h0, t});
		idle;
	endtask : xfer
	task t_reset;
		rdc("ctrl", FPS_CTRL_OFS, 32'h0);
		rdc("stat", FPS_STAT_OFS, 32'h0);
		apb(1'b1, 8'h10, 32'hFF);
		ck("werr", re, 1'b1);
		rdc("rdunmap", 8'h10, 32'h0);
		ck("rerr", re, 1'b1);
	endtask : t_reset
	task t_byte;
		txb <= 8'h5A;
		apb(1'b1, FPS_CTRL_OFS, 32'h1);
		idle;
		rdc("sel", FPS_STAT_OFS, 32'h4);
		ck("nopause", pact, 1'b0);
		xfer(8'hA5);
		ck("rx0", rxb, 8'hA5);
		ck("rxv", rxv, 1'b1);
		// Serial output floats, pulled high, until the first falling edge
		rdc("rxd0", FPS_RXD_OFS, 32'h80);
		xfer(8'h3C);
		ck("rx1", rxb, 8'h3C);
		rdc("rxd1", FPS_RXD_OFS, 32'h5A);
		apb(1'b1, FPS_CTRL_OFS, 32'h0);
		rdc("desel", FPS_STAT_OFS, 32'h0);
		ck("pos", bpos, 3'h0);
		ck("rxv0", rxv, 1'b0);
	endtask : t_byte
	task t_pause;
		apb(1'b1, FPS_CTRL_OFS, 32'h1);
		xfer(8'h81);
		apb(1'b1, FPS_CTRL_OFS, 32'h3);
		rdc("held", FPS_STAT_OFS, 32'h6);
		ck("pact", pact, 1'b1);
		ck("float", lnk.devIoOe, 4'h0);
		apb(1'b1, FPS_TXD_OFS, 32'hFF);
		rdc("nostart", FPS_STAT_OFS, 32'h6);
		ck("keep", rxb, 8'h81);
		apb(1'b1, FPS_CTRL_OFS, 32'h1);
		xfer(8'h42);
		ck("resume", rxb, 8'h42);
		ck("pact0", pact, 1'b0);
		apb(1'b1, FPS_CTRL_OFS, 32'h0);
	endtask : t_pause
	// Protect decode for one config
	task pr(input logic u, input logic l, input logic q, input logic e);
		spu <= u;
		spl <= l;
		qe <= q;
		@(posedge core_clk);
		@(posedge core_clk);
		ck("wblk", wblk, e);
	endtask : pr
	task t_protect;
		apb(1'b1, FPS_CTRL_OFS, 32'h4);
		rdc("ctrlrb", FPS_CTRL_OFS, 32'h4);
		pr(1'b0, 1'b1, 1'b0, 1'b1);
		pr(1'b1, 1'b1, 1'b0, 1'b0);
		pr(1'b0, 1'b0, 1'b0, 1'b0);
		pr(1'b0, 1'b1, 1'b1, 1'b0);
		pr(1'b0, 1'b1, 1'b0, 1'b1);
		apb(1'b1, FPS_CTRL_OFS, 32'h0);
		pr(1'b0, 1'b1, 1'b0, 1'b0);
	endtask : t_protect
	task t_hwreset;
		hrs <= 1'b1;
		apb(1'b1, FPS_CTRL_OFS, 32'h1);
		xfer(8'h11);
		apb(1'b1, FPS_CTRL_OFS, 32'h9);
		rdc("selr", FPS_STAT_OFS, 32'h4);
		ck("hrst", hrst, 1'b1);
		ck("nohold", pact, 1'b0);
		ck("rxclr", rxb, 8'h00);
		qe <= 1'b1;
		@(posedge core_clk);
		@(posedge core_clk);
		ck("qhrst", hrst, 1'b0);
		qe <= 1'b0;
		hrs <= 1'b0;
		apb(1'b1, FPS_CTRL_OFS, 32'h0);
	endtask : t_hwreset
	task t_quad;
		qe <= 1'b1;
		qx <= 1'b1;
		txb <= 8'h96;
		apb(1'b1, FPS_CTRL_OFS, 32'h11);
		idle;
		xfer(8'hC3);
		ck("qwr", rxb, 8'hC3);
		// Host releases the lines on the same edge that the device starts to drive
		apb(1'b1, FPS_CTRL_OFS, 32'h31);
		@(posedge core_clk);
		qr <= 1'b1;
		xfer(8'h00);
		rdc("qrd", FPS_RXD_OFS, 32'h96);
		apb(1'b1, FPS_CTRL_OFS, 32'h0);
		qr <= 1'b0;
		qx <= 1'b0;
		qe <= 1'b0;
	endtask : t_quad
	task print_verdict;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	// Hang guard, far beyond the expected run
	initial
	begin
		#200000;
		errors++;
		print_verdict;
	end
	// Main sequence
	initial
	begin
		{core_clk, rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
		{qe, spu, spl, hrs, qx, qr, txb} = '0;
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		t_reset;
		t_byte;
		t_pause;
		t_protect;
		t_hwreset;
		t_quad;
		print_verdict;
	end
endmodule : tb_flash_multifunction_pin_select
